// *** verilog/wdg_pkg.sv ***
// package: timing constants and variant encodings for the pin watchdog
package wdg_pkg;
  localparam int unsigned CLK_HZ        = 40000000;
  localparam int unsigned CLK_PERIOD_NS = 25;
  // timeout variants
  localparam logic [1:0] VAR_SHORT  = 2'h0;
  localparam logic [1:0] VAR_MID    = 2'h1;
  localparam logic [1:0] VAR_LONG   = 2'h2;
  localparam logic [1:0] VAR_XLONG  = 2'h3;
  // nominal times in their own units
  localparam int unsigned TMO_SHORT_US  = 3400;
  localparam int unsigned TMO_MID_US    = 6300;
  localparam int unsigned TMO_LONG_MS   = 102;
  localparam int unsigned TMO_XLONG_MS  = 1600;
  localparam int unsigned ACTIVE_MS     = 210;
  localparam int unsigned MIN_PULSE_US  = 10;
  localparam int unsigned VALID_PULSE_US = 1;
  localparam int unsigned GLITCH_NS     = 100;
  // cycle counts (whole clocks per unit, so every time is exact)
  localparam int unsigned TMO_SHORT_CYC = TMO_SHORT_US * (CLK_HZ / 1000000);
  localparam int unsigned TMO_MID_CYC   = TMO_MID_US * (CLK_HZ / 1000000);
  localparam int unsigned TMO_LONG_CYC  = TMO_LONG_MS * (CLK_HZ / 1000);
  localparam int unsigned TMO_XLONG_CYC = TMO_XLONG_MS * (CLK_HZ / 1000);
  localparam int unsigned ACTIVE_CYC    = ACTIVE_MS * (CLK_HZ / 1000);
  localparam int unsigned MIN_PULSE_CYC = MIN_PULSE_US * (CLK_HZ / 1000000);
  // filter: a level must persist one cycle past this to count; stays below the valid width
  localparam int unsigned FILT_CYC =
    (GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned VALID_CYC = VALID_PULSE_US * (CLK_HZ / 1000000);
  localparam int CNT_W  = 27;
  localparam int FILT_W = 4;
  // output drive styles
  localparam logic DRV_PUSH_PULL  = 1'b0;
  localparam logic DRV_OPEN_DRAIN = 1'b1;
endpackage

// *** verilog/wdg_top.sv ***
// pin watchdog: filtered kick and enable inputs, timeout counter, alarm output
// Operation
// - four timeout variants, 3.4 ms, 6.3 ms, 102 ms, 1.6 s, chosen by parameter.
// - while enabled, a missing kick within the timeout asserts the low alarm.
// - kick rising edge clears counter while counting; falling edge only in longer variants.
// - every alarm transition clears the counter and starts a new period.
// - a detected enable pulse clears the timeout counter.
// - kick pulses of 1 us count; shorter than 100 ns are rejected.
// - enable pulses of 1 us count; shorter than 100 ns are ignored.
// - static kick makes the alarm toggle repeatedly per variant timing.
// - counting starts once supply good; an uncleared timeout drives alarm low.
// - longer variants hold each alarm for the full active time while enabled, ignoring kicks.
// - shortest variant holds alarm at least 10 us, at most one timeout.
// - alarm is active low, open-drain or push-pull at build time.
// - kick and alarm behaviour only while enable input is low.
// - enable high early after power-up keeps alarm high, then one more timeout.
// - enable high releases alarm, but a started alarm lasts at least 10 us.
`timescale 1ns/1ps
module wdg_top #(
  parameter logic [1:0]  VARIANT       = wdg_pkg::VAR_SHORT,
  parameter logic        DRIVE         = wdg_pkg::DRV_PUSH_PULL,
  parameter int unsigned TIMEOUT_CYC   = (VARIANT == wdg_pkg::VAR_SHORT) ?
                                         wdg_pkg::TMO_SHORT_CYC :
                                         (VARIANT == wdg_pkg::VAR_MID) ?
                                         wdg_pkg::TMO_MID_CYC :
                                         (VARIANT == wdg_pkg::VAR_LONG) ?
                                         wdg_pkg::TMO_LONG_CYC :
                                         wdg_pkg::TMO_XLONG_CYC,
  parameter int unsigned ACTIVE_CYC    = wdg_pkg::ACTIVE_CYC,
  parameter int unsigned MIN_PULSE_CYC = wdg_pkg::MIN_PULSE_CYC
) (
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic supply_good,
  input  wire logic kick_input,
  input  wire logic enable_n,
  output logic      alarm_output_n,
  output logic      alarm_oe
);

  localparam logic [wdg_pkg::CNT_W-1:0] TMO_LAST =
    wdg_pkg::CNT_W'(TIMEOUT_CYC - 1);
  localparam logic [wdg_pkg::CNT_W-1:0] ACT_LAST =
    wdg_pkg::CNT_W'(ACTIVE_CYC - 1);
  localparam logic [wdg_pkg::CNT_W-1:0] MIN_LAST =
    wdg_pkg::CNT_W'(MIN_PULSE_CYC - 1);
  localparam logic [wdg_pkg::FILT_W-1:0] FILT_LAST =
    wdg_pkg::FILT_W'(wdg_pkg::FILT_CYC);
  localparam logic SHORT_VAR = (VARIANT == wdg_pkg::VAR_SHORT);

  // one-hot supervisor states
  typedef enum logic [3:0] {
    ST_OFF   = 4'h1,
    ST_COUNT = 4'h2,
    ST_ALARM = 4'h4,
    ST_HOLD  = 4'h8
  } wdg_state_t;

  // three-stage synchronisers
  logic [2:0] kick_sync_r;
  logic [2:0] en_sync_r;
  logic [2:0] pg_sync_r;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      kick_sync_r <= 3'h0;
      en_sync_r   <= 3'h0;
      pg_sync_r   <= 3'h0;
    end else begin
      kick_sync_r <= {kick_sync_r[1:0], kick_input};
      en_sync_r   <= {en_sync_r[1:0], enable_n};
      pg_sync_r   <= {pg_sync_r[1:0], supply_good};
    end
  end

  wire kick_agree = (kick_sync_r[2] == kick_sync_r[1]);
  wire en_agree   = (en_sync_r[2] == en_sync_r[1]);

  // glitch filters: new level accepted after it persists past the glitch time
  logic                      kick_f_r;
  logic                      en_f_r;
  logic [wdg_pkg::FILT_W-1:0] kick_cnt_r;
  logic [wdg_pkg::FILT_W-1:0] en_cnt_r;
  wire kick_diff = kick_agree && (kick_sync_r[2] != kick_f_r);
  wire en_diff   = en_agree && (en_sync_r[2] != en_f_r);
  wire kick_take = kick_diff && (kick_cnt_r == FILT_LAST);
  wire en_take   = en_diff && (en_cnt_r == FILT_LAST);
  wire [wdg_pkg::FILT_W-1:0] kick_cnt_nxt =
    kick_diff ? (kick_take ? '0 : kick_cnt_r + 1'b1) : '0;
  wire [wdg_pkg::FILT_W-1:0] en_cnt_nxt =
    en_diff ? (en_take ? '0 : en_cnt_r + 1'b1) : '0;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      kick_f_r   <= 1'b0;
      en_f_r     <= 1'b0;
      kick_cnt_r <= '0;
      en_cnt_r   <= '0;
    end else begin
      kick_cnt_r <= kick_cnt_nxt;
      en_cnt_r   <= en_cnt_nxt;
      if (kick_take) begin
        kick_f_r <= ~kick_f_r;
      end
      if (en_take) begin
        en_f_r <= ~en_f_r;
      end
    end
  end

  wire kick_rise = kick_take && !kick_f_r;
  wire kick_fall = kick_take && kick_f_r;
  wire kick_clr  = kick_rise || (kick_fall && !SHORT_VAR);
  wire en_fall   = en_take && en_f_r; // end of a high enable pulse
  wire enabled   = !en_f_r;

  // supply good counts once the last two synchroniser stages agree
  logic powered_r;
  wire  pg_agree = (pg_sync_r[2] == pg_sync_r[1]);
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      powered_r <= 1'b0;
    end else if (pg_agree) begin
      powered_r <= pg_sync_r[2];
    end
  end
  wire powered   = powered_r;

  // supervisor state, timeout counter and alarm flag
  wdg_state_t                 state_r;
  wdg_state_t                 state_nxt;
  logic [wdg_pkg::CNT_W-1:0]  cnt_r;
  logic [wdg_pkg::CNT_W-1:0]  cnt_nxt;
  logic                       alarm_r;
  logic                       alarm_nxt;

  wire tmo_hit = (cnt_r == TMO_LAST);
  wire act_hit = (cnt_r == ACT_LAST);
  wire min_met = (cnt_r >= MIN_LAST);
  wire [wdg_pkg::CNT_W-1:0] cnt_inc = cnt_r + 1'b1;

  // alarm end conditions per variant
  wire short_end = SHORT_VAR && ((kick_clr && min_met) || tmo_hit);
  wire long_end  = !SHORT_VAR && act_hit;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_inc;
    alarm_nxt = alarm_r;
    case (state_r)
      ST_OFF: begin
        cnt_nxt = '0;
        if (powered && enabled) begin
          state_nxt = ST_COUNT;
        end
      end
      ST_COUNT: begin
        if (!powered) begin
          state_nxt = ST_OFF;
        end else if (!enabled) begin
          cnt_nxt = '0; // held high, a full period follows the enable drop
        end else if (kick_clr || en_fall) begin
          cnt_nxt = '0;
        end else if (tmo_hit) begin
          state_nxt = ST_ALARM;
          alarm_nxt = 1'b1;
          cnt_nxt   = '0;
        end
      end
      ST_ALARM: begin
        if (!enabled) begin
          state_nxt = ST_HOLD;
        end else if (SHORT_VAR) begin
          if (short_end) begin
            state_nxt = ST_COUNT;
            alarm_nxt = 1'b0;
            cnt_nxt   = '0;
          end
        end else if (long_end) begin
          state_nxt = ST_COUNT; // kicks ignored until the active time ends
          alarm_nxt = 1'b0;
          cnt_nxt   = '0;
        end
      end
      ST_HOLD: begin
        if (min_met) begin
          state_nxt = ST_COUNT;
          alarm_nxt = 1'b0;
          cnt_nxt   = '0;
        end
      end
      default: begin
        state_nxt = ST_OFF;
        cnt_nxt   = '0;
        alarm_nxt = 1'b0;
      end
    endcase
  end

  // state registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_OFF;
      cnt_r   <= '0;
      alarm_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      alarm_r <= alarm_nxt;
    end
  end

  // open-drain drives only low; push-pull always drives
  wire od_mode    = (DRIVE == wdg_pkg::DRV_OPEN_DRAIN);
  wire pp_level_n = ~alarm_r;
  assign alarm_output_n = od_mode ? 1'b0 : pp_level_n;
  assign alarm_oe       = od_mode ? alarm_r : 1'b1;

endmodule // wdg_top

// *** test/wdg_mcu.sv ***
// partner: controller model that kicks the watchdog
`timescale 1ns/1ps
module wdg_mcu (
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic [7:0] half_per,
  input  wire logic       glitch,
  output logic            kick
);
  logic [7:0] cnt_r;
  // toggles every half_per+1 cycles, zero holds still; glitch drops it after 3 cycles
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 8'h0;
      kick  <= 1'b0;
    end else begin
      cnt_r <= (cnt_r >= half_per) ? 8'h0 : cnt_r + 8'h1;
      if (half_per != 8'h0 && cnt_r == half_per) kick <= !kick;
      else if (glitch && cnt_r == 8'h2) kick <= 1'b0;
    end
  end
endmodule // wdg_mcu

// *** test/wdg_top_sva.sv ***
// checker: port assertions of the pin watchdog
`timescale 1ns/1ps
module wdg_chk #(
  parameter int unsigned TIMEOUT_CYC = 200
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic supply_good,
  input wire logic kick_input,
  input wire logic enable_n,
  input wire logic alarm_output_n,
  input wire logic alarm_oe
);
  localparam int TMO_B = 210;
  logic [15:0] q_cnt_r;
  logic [15:0] r_cnt_r;
  logic [15:0] e_cnt_r;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      q_cnt_r <= 16'h0;
      r_cnt_r <= 16'h0;
      e_cnt_r <= 16'h0;
    end else begin
      q_cnt_r <= (enable_n || !supply_good || $changed(alarm_output_n) || $changed(kick_input))
                 ? 16'h0 : q_cnt_r + 16'h1;
      r_cnt_r <= (e_cnt_r > 16'h3 || !supply_good || $changed(alarm_output_n))
                 ? 16'h0 : r_cnt_r + 16'h1;
      e_cnt_r <= enable_n ? e_cnt_r + 16'h1 : 16'h0;
    end
  end
  a_oe_driven: assert property (alarm_oe) else $error("oe low in push-pull");
  a_reset_rel: assert property ($rose(rst_n) |-> alarm_output_n) else $error("alarm at reset");
  a_min_pulse: assert property ($fell(alarm_output_n) |=> !alarm_output_n [*8])
    else $error("alarm pulse too short");
  a_alarm_ends: assert property ($fell(alarm_output_n) |-> ##[1:TMO_B] alarm_output_n)
    else $error("alarm pulse too long");
  a_timeout_fires: assert property (q_cnt_r <= TIMEOUT_CYC + 20)
    else $error("no alarm after timeout");
  a_no_early: assert property ($fell(alarm_output_n) |-> r_cnt_r >= TIMEOUT_CYC - 3)
    else $error("alarm before timeout");
  a_dis_quiet: assert property (e_cnt_r > 16'd40 |-> alarm_output_n)
    else $error("alarm while disabled");
  a_kick_ends: assert property ((!alarm_output_n && !enable_n && $rose(kick_input)) ##1
    kick_input [*7] |-> ##[1:30] alarm_output_n) else $error("kick did not end alarm");
  c_alarm: cover property ($fell(alarm_output_n));
  c_dis: cover property (e_cnt_r > 16'd40);
  c_kick_end: cover property (!alarm_output_n ##1 alarm_output_n && kick_input);
endmodule // wdg_chk
bind wdg_top wdg_chk #(.TIMEOUT_CYC(TIMEOUT_CYC)) i_chk (.clock(clock), .rst_n(rst_n),
  .supply_good(supply_good), .kick_input(kick_input), .enable_n(enable_n),
  .alarm_output_n(alarm_output_n), .alarm_oe(alarm_oe));

// *** test/testbench.sv ***
// testbench: row-driven and hand-written checks of the pin watchdog
`timescale 1ns/1ps
module testbench;
  typedef struct packed { logic [7:0] half_per; logic glitch; logic alarm_exp; } wdg_row_t;
  localparam wdg_row_t ROWS [5] = '{'{8'h19, 1'b0, 1'b0}, '{8'h5a, 1'b0, 1'b0},
    '{8'h78, 1'b0, 1'b1}, '{8'h00, 1'b0, 1'b1}, '{8'h28, 1'b1, 1'b1}};
  logic       clock;
  logic       rst_n;
  logic       supply_good;
  logic       enable_n;
  logic       kick_input;
  logic       alarm_output_n;
  logic       alarm_oe;
  logic       alarm_q;
  logic [7:0] half_per;
  logic       glitch;
  int         falls;
  int         cycles;
  int         bad_count;
  int         cmp_count;
  wdg_top #(.VARIANT(wdg_pkg::VAR_SHORT), .DRIVE(wdg_pkg::DRV_PUSH_PULL), .TIMEOUT_CYC(200),
    .ACTIVE_CYC(100), .MIN_PULSE_CYC(10)) i_dut (.clock(clock), .rst_n(rst_n),
    .supply_good(supply_good), .kick_input(kick_input), .enable_n(enable_n),
    .alarm_output_n(alarm_output_n), .alarm_oe(alarm_oe));
  wdg_mcu i_mcu (.clock(clock), .rst_n(rst_n), .half_per(half_per), .glitch(glitch),
    .kick(kick_input));
  task automatic check(input string name, input logic seen, input logic exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %b seen %b", name, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // sets the kick pattern, clears through a long enable pulse, then keeps running it
  task automatic run_row(input logic [7:0] hp, input logic gl, input logic dis, input int n);
    enable_n = 1'b1;
    half_per = hp;
    glitch   = gl;
    repeat (60) @(posedge clock);
    #2 enable_n = dis;
    falls = 0;
    repeat (n) @(posedge clock);
    #2;
  endtask
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  always @(posedge clock) begin
    alarm_q <= alarm_output_n;
    if (alarm_q && !alarm_output_n) falls = falls + 1;
    cycles = cycles + 1;
    if (cycles == 8000) begin
      bad_count++;
      print_verdict();
    end
  end
  initial begin
    rst_n       = 1'b0;
    supply_good = 1'b0;
    enable_n    = 1'b0;
    half_per    = 8'h00;
    glitch      = 1'b0;
    repeat (16) @(posedge clock);
    #2 rst_n = 1'b1;
    check("alarm_rst", alarm_output_n, 1'b1);
    check("oe_rst", alarm_oe, 1'b1);
    supply_good = 1'b1;
    foreach (ROWS[i]) begin
      run_row(ROWS[i].half_per, ROWS[i].glitch, 1'b0, 700);
      check("alarm_row", falls != 0, ROWS[i].alarm_exp);
    end
    run_row(8'h00, 1'b0, 1'b1, 600);
    check("alarm_dis", falls != 0, 1'b0);
    run_row(8'h00, 1'b0, 1'b0, 150);
    enable_n = 1'b1;
    repeat (3) @(posedge clock);
    #2 enable_n = 1'b0;
    repeat (77) @(posedge clock);
    #2 check("en_glitch", alarm_output_n, 1'b0);
    print_verdict();
  end
endmodule // testbench
